// [core/watchdog_reset_status.sv]
// Watchdog control and reset-cause status behind an AXI4-Lite slave.
// Assumes one 250 MHz clock; reset sources and the fuse arrive unsynchronised.
//
// What this block does
// R1 - Scan reset sets its cause flag
// R2 - Watchdog reset sets its cause flag
// R3 - Brown-out reset sets its cause flag
// R4 - Pin reset sets its cause flag
// R5 - Power-up flag cleared only by software
// R6 - Software reads then clears flags early
// R7 - Control bits 7:5 read as zero
// R8 - Change-enable self-clears four cycles later
// R9 - Enable clears only with change-enable set or on a chip reset
// R10 - Timeout change needs change-enable active
// R11 - Disable needs open then zero write
// R12 - Always-on fuse keeps watchdog enabled
// R13 - Select doubles expiry from 16K ticks
// R14 - Select matters only while enabled
// R15 - Restart count on kick, disable, reset
// R16 - Expiry gives one-cycle reset pulse
// R17 - Fuse level: enable reads one from reset
// R18 - Select and disable applied only inside open window
// R19 - Select writes outside window ignored
`timescale 1ns/100ps
module watchdog_reset_status #(
  parameter int OSC_DIV    = wdt_pkg::OSC_DIV,
  parameter int BASE_TICKS = wdt_pkg::BASE_TICKS,
  parameter int WIN_CYCLES = wdt_pkg::WIN_CYCLES
) (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic [wdt_pkg::ADDR_W-1:0]  awaddr,
  input  wire logic                        awvalid,
  output logic                             awready,
  input  wire logic [wdt_pkg::DATA_W-1:0]  wdata,
  input  wire logic [3:0]                  wstrb,
  input  wire logic                        wvalid,
  output logic                             wready,
  output logic [1:0]                       bresp,
  output logic                             bvalid,
  input  wire logic                        bready,
  input  wire logic [wdt_pkg::ADDR_W-1:0]  araddr,
  input  wire logic                        arvalid,
  output logic                             arready,
  output logic [wdt_pkg::DATA_W-1:0]       rdata,
  output logic [1:0]                       rresp,
  output logic                             rvalid,
  input  wire logic                        rready,
  input  wire logic                        pinReset_n,
  input  wire logic                        supplyDropReset,
  input  wire logic                        scanResetInstruction,
  input  wire logic                        alwaysOnFuse,
  input  wire logic                        kickPulse,
  output logic                             sysResetPulse,
  output logic                             irq
);
  import wdt_pkg::*;

  localparam int WIN_W = $clog2(WIN_CYCLES + 1);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Word decode shared by both channels
  function automatic logic isReg(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    isReg = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
  endfunction : isReg

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic [3:0] asyncIn;   // {fuse, scan, supply, pin}
  logic [3:0] syncA_ff;  // First stage, read only by second
  logic [3:0] syncB_ff;  // Safe levels
  assign asyncIn = {alwaysOnFuse, scanResetInstruction, supplyDropReset, ~pinReset_n};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : gSync
      // Two flops per asynchronous source
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          syncA_ff[gi] <= 1'b0;
          syncB_ff[gi] <= 1'b0;
        end else begin
          syncA_ff[gi] <= asyncIn[gi];
          syncB_ff[gi] <= syncA_ff[gi];
        end
      end
    end
  endgenerate

  logic              level2;     // Always-on fuse in force
  logic              wdtExpire;  // Expiry from counter
  logic              chipReset;  // Any non-power-up reset source
  logic [FLAG_W-1:0] causeSet;   // Flags to set this cycle
  assign level2    = syncB_ff[3];
  assign chipReset = wdtExpire | (|syncB_ff[2:0]);
  // Sources stay asserted as levels, so flags keep setting while held
  assign causeSet  = {syncB_ff[2], wdtExpire, syncB_ff[1], syncB_ff[0], 1'b0}; // [R1] [R2] [R3] [R4]

  // ************************************************************
  // AXI4-Lite write channel
  // ************************************************************
  logic              awready_ff, wready_ff, bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              awHeld_ff, wHeld_ff;  // Address / data captured
  logic [ADDR_W-1:0] wAddr_ff;             // Captured address
  logic [7:0]        wData_ff;             // Captured low byte
  logic              wLane0_ff;            // Low byte lane strobed
  logic              doWrite, wrEn, wrHit;

  assign doWrite = awHeld_ff & wHeld_ff & ~bvalid_ff;
  assign wrEn    = doWrite & wLane0_ff;
  assign wrHit   = isReg(wAddr_ff, CAUSE_OFS) | isReg(wAddr_ff, CTRL_OFS) |
                   isReg(wAddr_ff, IRQST_OFS) | isReg(wAddr_ff, IRQMSK_OFS);

  // Address capture; ready returns only after the response is taken
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awready_ff <= 1'b1;
      awHeld_ff  <= 1'b0;
      wAddr_ff   <= '0;
    end else if (awvalid && awready_ff) begin
      awready_ff <= 1'b0;
      awHeld_ff  <= 1'b1;
      wAddr_ff   <= awaddr;
    end else if (doWrite) begin
      awHeld_ff  <= 1'b0;
    end else if (bvalid_ff && bready) begin
      awready_ff <= 1'b1;
    end
  end

  // Data capture, independent of address order
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wready_ff <= 1'b1;
      wHeld_ff  <= 1'b0;
      wData_ff  <= '0;
      wLane0_ff <= 1'b0;
    end else if (wvalid && wready_ff) begin
      wready_ff <= 1'b0;
      wHeld_ff  <= 1'b1;
      wData_ff  <= wdata[7:0];
      wLane0_ff <= wstrb[0];
    end else if (doWrite) begin
      wHeld_ff  <= 1'b0;
    end else if (bvalid_ff && bready) begin
      wready_ff <= 1'b1;
    end
  end

  // Response; unmapped addresses answer SLVERR
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else if (doWrite) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= wrHit ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  logic causeWr, ctrlWr, irqStWr, maskWr, openWr;
  assign causeWr = wrEn & isReg(wAddr_ff, CAUSE_OFS);
  assign ctrlWr  = wrEn & isReg(wAddr_ff, CTRL_OFS);
  assign irqStWr = wrEn & isReg(wAddr_ff, IRQST_OFS);
  assign maskWr  = wrEn & isReg(wAddr_ff, IRQMSK_OFS);
  assign openWr  = ctrlWr & wData_ff[CE_BIT] & wData_ff[EN_BIT]; // [R11]

  // ************************************************************
  // Watchdog control
  // ************************************************************
  logic             changeEnable_ff;  // Window open
  logic [WIN_W-1:0] winCnt_ff;        // Cycles left in window
  logic             wdtEnable_ff;     // Software enable
  logic [SEL_W-1:0] timeoutSel_ff;    // Timeout select
  logic             effEnable;        // Enable after fuse

  // Window opens on a write of both bits and closes by itself
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      changeEnable_ff <= 1'b0;
      winCnt_ff       <= '0;
    end else if (chipReset) begin
      changeEnable_ff <= 1'b0;
      winCnt_ff       <= '0;
    end else if (openWr) begin
      changeEnable_ff <= 1'b1;
      winCnt_ff       <= WIN_W'(WIN_CYCLES);
    end else if (winCnt_ff != '0) begin
      winCnt_ff       <= winCnt_ff - WIN_W'(1);
      if (winCnt_ff == WIN_W'(1)) begin
        changeEnable_ff <= 1'b0; // [R8]
      end
    end
  end

  // Setting is free; clearing needs the window
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wdtEnable_ff <= 1'b0;
    end else if (chipReset) begin
      // Other reset sources clear the software enable too
      wdtEnable_ff <= 1'b0;
    end else if (ctrlWr && wData_ff[EN_BIT]) begin
      wdtEnable_ff <= 1'b1; // [R9]
    end else if (ctrlWr && changeEnable_ff) begin
      wdtEnable_ff <= 1'b0; // [R9] [R11] [R18]
    end
  end

  // Select written only inside an open window
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timeoutSel_ff <= '0;
    end else if (chipReset) begin
      // Chip reset returns the select to its shortest span
      timeoutSel_ff <= '0;
    end else if (ctrlWr && changeEnable_ff) begin
      timeoutSel_ff <= wData_ff[SEL_W-1:0]; // [R10] [R18] [R19]
    end
  end

  // Fuse overrides any disable and reads back as enabled
  assign effEnable = wdtEnable_ff | level2; // [R12] [R17]

  wdt_counter #(
    .OSC_DIV    (OSC_DIV),
    .BASE_TICKS (BASE_TICKS),
    .CNT_W      (CNT_W)
  ) uCounter (
    .clk     (clk),
    .rst     (rst),
    .enable  (effEnable),
    .restart (kickPulse | chipReset), // [R15]
    .sel     (timeoutSel_ff),
    .expire  (wdtExpire)
  );

  // ************************************************************
  // Reset pulse, cause flags, interrupt
  // ************************************************************
  logic              sysResetPulse_ff;  // One-cycle reset request
  logic [FLAG_W-1:0] causeFlag_ff;      // reset_cause_status
  logic [FLAG_W-1:0] irqStatus_ff;      // Sticky events
  logic [FLAG_W-1:0] irqMask_ff;        // Event mask
  logic              irq_ff;            // Interrupt level

  // Expiry is already one cycle wide
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sysResetPulse_ff <= 1'b0;
    end else begin
      sysResetPulse_ff <= wdtExpire; // [R16]
    end
  end

  // Write zero clears; a set in the same cycle wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      causeFlag_ff <= CAUSE_RST; // [R5]
    end else begin
      causeFlag_ff <= (causeFlag_ff & ~(causeWr ? ~wData_ff[FLAG_W-1:0] : '0)) | causeSet;
    end
  end

  // Interrupt events use the cause layout, write one clears
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irqStatus_ff <= '0;
      irqMask_ff   <= '0;
      irq_ff       <= 1'b0;
    end else begin
      irqStatus_ff <= (irqStatus_ff & ~(irqStWr ? wData_ff[FLAG_W-1:0] : '0)) | causeSet;
      irqMask_ff   <= maskWr ? wData_ff[FLAG_W-1:0] : irqMask_ff;
      irq_ff       <= |(irqStatus_ff & irqMask_ff);
    end
  end

  // ************************************************************
  // AXI4-Lite read channel
  // ************************************************************
  logic              arready_ff, rvalid_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [1:0]        rresp_ff;
  logic [7:0]        rdByte;
  logic              rdHit;

  // Upper bits of every register read as zero
  always_comb begin
    rdByte = 8'h00; // [R7]
    rdHit  = 1'b1;
    if (isReg(araddr, CAUSE_OFS)) begin
      rdByte[FLAG_W-1:0] = causeFlag_ff;
    end else if (isReg(araddr, CTRL_OFS)) begin
      rdByte[CE_BIT]      = changeEnable_ff;
      rdByte[EN_BIT]      = effEnable; // [R17]
      rdByte[SEL_W-1:0]   = timeoutSel_ff;
    end else if (isReg(araddr, IRQST_OFS)) begin
      rdByte[FLAG_W-1:0] = irqStatus_ff;
    end else if (isReg(araddr, IRQMSK_OFS)) begin
      rdByte[FLAG_W-1:0] = irqMask_ff;
    end else begin
      rdHit = 1'b0;
    end
  end

  // One read at a time, answered the cycle after address
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= '0;
      rresp_ff   <= RESP_OKAY;
    end else if (arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rdata_ff   <= {24'h000000, rdByte};
      rresp_ff   <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_ff && rready) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
    end
  end

  assign awready       = awready_ff;
  assign wready        = wready_ff;
  assign bvalid        = bvalid_ff;
  assign bresp         = bresp_ff;
  assign arready       = arready_ff;
  assign rvalid        = rvalid_ff;
  assign rdata         = rdata_ff;
  assign rresp         = rresp_ff;
  assign sysResetPulse = sysResetPulse_ff;
  assign irq           = irq_ff;

  // ************************************************************
  // Checks
  // ************************************************************
  AST_CE_SELF_CLEAR: assert property ( // [R8]
    $rose(changeEnable_ff) ##1 (!openWr)[*4] |-> !changeEnable_ff)
    else $error("change enable did not clear after four cycles");
  AST_RESERVED_ZERO: assert property (rvalid_ff |-> rdata_ff[DATA_W-1:5] == '0) // [R7]
    else $error("reserved bits read non-zero");
  AST_DISABLE_GUARDED: assert property ( // [R9] [R11]
    $fell(wdtEnable_ff) |-> $past(changeEnable_ff) || $past(chipReset))
    else $error("enable cleared without open window");
  AST_FUSE_READS_ON: assert property ( // [R12] [R17]
    (arvalid && arready_ff && isReg(araddr, CTRL_OFS) && level2) |=> rdata_ff[EN_BIT])
    else $error("enable read as zero under fuse");
  AST_SEL_GUARDED: assert property ( // [R10] [R19]
    $changed(timeoutSel_ff) |-> $past(changeEnable_ff) || $past(chipReset))
    else $error("select changed outside window");
  AST_PULSE_ONE_CYCLE: assert property (sysResetPulse_ff |=> !sysResetPulse_ff) // [R16]
    else $error("reset pulse longer than one cycle");
  AST_TIMEOUT_FLAG: assert property (wdtExpire |=> causeFlag_ff[TIMEOUT_BIT] && sysResetPulse_ff) // [R2]
    else $error("expiry did not flag and pulse");
  AST_CAUSE_SET: assert property ( // [R1] [R3] [R4]
    (|causeSet) |=> ((causeFlag_ff & $past(causeSet)) == $past(causeSet)))
    else $error("cause flag not set");
  AST_POWER_FLAG_KEEP: assert property ( // [R5]
    $fell(causeFlag_ff[POWER_BIT]) |-> $past(causeWr) && !$past(wData_ff[POWER_BIT]))
    else $error("power-up flag cleared without write");

endmodule : watchdog_reset_status

// [core/wdt_pkg.sv]
// Constants for the watchdog and reset-cause block.
// Assumes a single 250 MHz system clock and an AXI4-Lite register port.
package wdt_pkg;

  // ************************************************************
  // Register map (byte addresses, one aligned word each)
  // ************************************************************
  localparam int             ADDR_W     = 8;      // Register address width
  localparam int             DATA_W     = 32;     // Bus data width
  localparam logic [7:0]     CAUSE_OFS  = 8'h00;  // reset_cause_status
  localparam logic [7:0]     CTRL_OFS   = 8'h04;  // watchdog_control
  localparam logic [7:0]     IRQST_OFS  = 8'h08;  // Interrupt status
  localparam logic [7:0]     IRQMSK_OFS = 8'h0C;  // Interrupt mask

  // ************************************************************
  // Field layout
  // ************************************************************
  localparam int             FLAG_W     = 5;      // Cause flags, bits 4:0
  localparam int             POWER_BIT  = 0;      // power_up_reset_flag
  localparam int             PIN_BIT    = 1;      // pin_reset_flag
  localparam int             SUPPLY_BIT = 2;      // supply_drop_reset_flag
  localparam int             TIMEOUT_BIT = 3;     // timeout_reset_flag
  localparam int             SCAN_BIT   = 4;      // scan_reset_flag
  localparam int             SEL_W      = 3;      // timeout_select width
  localparam int             EN_BIT     = 3;      // watchdog_enable
  localparam int             CE_BIT     = 4;      // change_enable
  localparam logic [4:0]     CAUSE_RST  = 5'h01;  // Power-up flag set
  localparam logic [1:0]     RESP_OKAY  = 2'h0;   // AXI OKAY
  localparam logic [1:0]     RESP_SLVERR = 2'h2;  // AXI SLVERR

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int             CLK_MHZ    = 250;    // System clock, MHz
  localparam int             OSC_MHZ    = 1;      // Watchdog oscillator, MHz
  localparam int             OSC_DIV    = CLK_MHZ / OSC_MHZ; // Clocks per tick
  localparam int             BASE_TICKS = 16384;  // 16K ticks at select 000
  localparam int             WIN_CYCLES = 4;      // Change window, clocks
  localparam int             CNT_W      = 22;     // Holds 2,048K ticks

endpackage : wdt_pkg

// [core/wdt_counter.sv]
// Watchdog tick divider and expiry counter.
// Assumes restart and enable come from logic on the same clock.
`timescale 1ns/100ps
module wdt_counter #(
  parameter int OSC_DIV    = wdt_pkg::OSC_DIV,
  parameter int BASE_TICKS = wdt_pkg::BASE_TICKS,
  parameter int CNT_W      = wdt_pkg::CNT_W
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     enable,
  input  wire logic                     restart,
  input  wire logic [wdt_pkg::SEL_W-1:0] sel,
  output logic                          expire
);
  import wdt_pkg::*;

  localparam int DIV_W = $clog2(OSC_DIV + 1);

  logic [DIV_W-1:0] divCnt_ff;  // Oscillator divider
  logic             tick;       // One-cycle oscillator tick
  logic [CNT_W-1:0] tickCnt_ff; // Ticks since restart
  logic [CNT_W-1:0] limit;      // Expiry count for sel
  logic             expire_ff;  // Expiry pulse

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ************************************************************
  // Oscillator tick
  // ************************************************************
  // Stands in for the separate oscillator; it free-runs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      divCnt_ff <= '0;
    end else if (divCnt_ff == DIV_W'(OSC_DIV - 1)) begin
      divCnt_ff <= '0;
    end else begin
      divCnt_ff <= divCnt_ff + DIV_W'(1);
    end
  end
  assign tick = (divCnt_ff == DIV_W'(OSC_DIV - 1));

  // Count doubles per select step
  assign limit = CNT_W'(BASE_TICKS) << sel; // [R13]

  // ************************************************************
  // Expiry counter
  // ************************************************************
  // Held at zero while disabled, so sel only matters when enabled
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tickCnt_ff <= '0;
      expire_ff  <= 1'b0;
    end else if (restart || !enable) begin // [R15] [R14]
      tickCnt_ff <= '0;
      expire_ff  <= 1'b0;
    end else if (tick && tickCnt_ff >= limit - CNT_W'(1)) begin
      tickCnt_ff <= '0;
      expire_ff  <= 1'b1; // [R13]
    end else begin
      tickCnt_ff <= tick ? tickCnt_ff + CNT_W'(1) : tickCnt_ff;
      expire_ff  <= 1'b0;
    end
  end
  assign expire = expire_ff;

  AST_RESTART_CLEARS: assert property (restart |=> tickCnt_ff == '0) // [R15]
    else $error("count not cleared by restart");
  AST_EXPIRY_AT_LIMIT: assert property ( // [R13]
    (enable && !restart && tick && tickCnt_ff == limit - CNT_W'(1)) |=> expire_ff)
    else $error("no expiry at selected count");

endmodule : wdt_counter

// [bench/watchdog_reset_status_tb.sv]
// Self-checking bench for the watchdog and reset-cause block.
// Assumes the design package is compiled first; the bench is the bus master.
`timescale 1ns/100ps
module watchdog_reset_status_tb;
  import wdt_pkg::*;
  // ************************************************************
  // Signals and counters
  // ************************************************************
  logic        clk, rst;                         // Clock, power-up reset
  logic [7:0]  awaddr, araddr;                   // Bus addresses
  logic [31:0] wdata, rdata;                     // Bus data
  logic [3:0]  wstrb;                            // Byte lanes
  logic [1:0]  bresp, rresp;                     // Responses
  logic        awvalid, awready, wvalid, wready; // Write channels
  logic        bvalid, bready, arvalid, arready; // Response and read address
  logic        rvalid, rready;                   // Read data
  logic        pinReset_n, supplyDropReset;      // Reset sources
  logic        scanResetInstruction, alwaysOnFuse, kickPulse;
  logic        sysResetPulse, irq;               // Outputs under test
  int          err_total, comparisons;           // Mismatches, checks
  logic [31:0] rd;                               // Scratch read data
  logic [1:0]  rs;                               // Scratch response
  int          n, seen;                          // Cycle and pulse counts

  // Short counts keep expiry at 8 clocks for select 000
  watchdog_reset_status #(.OSC_DIV(2), .BASE_TICKS(4), .WIN_CYCLES(4)) dut (
    .clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .pinReset_n(pinReset_n), .supplyDropReset(supplyDropReset),
    .scanResetInstruction(scanResetInstruction), .alwaysOnFuse(alwaysOnFuse),
    .kickPulse(kickPulse), .sysResetPulse(sysResetPulse), .irq(irq));

  // Clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ************************************************************
  // Compare, bus and closing tasks
  // ************************************************************
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t resp got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_resp

  // Address and data offered together, each released once taken
  // Waits for the answer however long; only the watchdog ends a hang
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awaddr <= a; wdata <= d; wstrb <= 4'hF;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_read

  // Write expecting OKAY; read and compare a register
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_write(a, d, rs);
    chk_resp(rs, RESP_OKAY);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    axi_read(a, rd, rs);
    chk_resp(rs, RESP_OKAY);
    chk_val(rd, exp);
  endtask : rd_chk

  // Counts clocks until the expiry pulse, then checks it lasted one clock
  task automatic wait_pulse(input int lim);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (sysResetPulse !== 1'b1 && n < lim);
    chk_val({31'h0, sysResetPulse}, 32'h1);
    @(posedge clk);
    chk_val({31'h0, sysResetPulse}, 32'h0);
  endtask : wait_pulse

  task automatic hold_reset;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : hold_reset

  task automatic end_of_test;
    $display("Counts: %0d mismatches in %0d comparisons", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  // ************************************************************
  // Scenarios
  // ************************************************************
  // Reset-cause flags, software clear, interrupt mask and clear
  task automatic t_causes;
    rd_chk(CAUSE_OFS, 32'h01);
    rd_chk(CTRL_OFS, 32'h00);
    axi_read(8'h10, rd, rs);
    chk_resp(rs, RESP_SLVERR);
    wr(IRQMSK_OFS, 32'h1F);
    wr(CAUSE_OFS, 32'h00);
    rd_chk(CAUSE_OFS, 32'h00);
    @(posedge clk) pinReset_n <= 1'b0;
    repeat (5) @(posedge clk);
    pinReset_n <= 1'b0;
    @(posedge clk) pinReset_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk(CAUSE_OFS, 32'h02);
    @(posedge clk) supplyDropReset <= 1'b1;
    repeat (5) @(posedge clk);
    supplyDropReset <= 1'b0;
    repeat (4) @(posedge clk);
    rd_chk(CAUSE_OFS, 32'h06);
    @(posedge clk) scanResetInstruction <= 1'b1;
    repeat (5) @(posedge clk);
    scanResetInstruction <= 1'b0;
    repeat (4) @(posedge clk);
    rd_chk(CAUSE_OFS, 32'h16);
    rd_chk(IRQST_OFS, 32'h16);
    chk_val({31'h0, irq}, 32'h1);
    wr(IRQMSK_OFS, 32'h00);
    repeat (2) @(posedge clk);
    chk_val({31'h0, irq}, 32'h0);
    wr(IRQMSK_OFS, 32'h1F);
    repeat (2) @(posedge clk);
    chk_val({31'h0, irq}, 32'h1);
    wr(IRQST_OFS, 32'h1F);
    repeat (2) @(posedge clk);
    chk_val({31'h0, irq}, 32'h0);
    wr(CAUSE_OFS, 32'h00);
    rd_chk(CAUSE_OFS, 32'h00);
    $display("Test causes done");
  endtask : t_causes

  // Guarded enable, timed window, reserved bits
  task automatic t_window;
    kickPulse <= 1'b1; // Held restart keeps the short expiry away
    wr(CTRL_OFS, 32'hFF);
    repeat (10) @(posedge clk);
    rd_chk(CTRL_OFS, 32'h08);
    wr(CTRL_OFS, 32'h05);
    rd_chk(CTRL_OFS, 32'h08);
    wr(CTRL_OFS, 32'h18);
    wr(CTRL_OFS, 32'h05);
    rd_chk(CTRL_OFS, 32'h05);
    wr(CTRL_OFS, 32'h08);
    rd_chk(CTRL_OFS, 32'h0D);
    $display("Test window done");
  endtask : t_window

  // Restart by kicks, expiry pulse, timeout flag, select span
  task automatic t_expiry;
    wr(CTRL_OFS, 32'h18);
    wr(CTRL_OFS, 32'h08);
    seen = 0;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      kickPulse <= (i % 4 == 0);
      if (sysResetPulse === 1'b1) seen++;
    end
    chk_val(seen, 0);
    wait_pulse(40);
    chk_val({31'h0, (n > 5 && n < 10)}, 32'h1);
    rd_chk(CAUSE_OFS, 32'h08);
    rd_chk(CTRL_OFS, 32'h00);
    wr(CTRL_OFS, 32'h18);
    wr(CTRL_OFS, 32'h0F);
    wait_pulse(1200);
    chk_val({31'h0, (n > 1000 && n < 1030)}, 32'h1);
    $display("Test expiry done");
  endtask : t_expiry

  // Always-on level: enabled from reset, disable sequence has no effect
  task automatic t_fuse;
    @(posedge clk) alwaysOnFuse <= 1'b1;
    kickPulse <= 1'b1;
    hold_reset();
    rd_chk(CAUSE_OFS, 32'h01);
    rd_chk(CTRL_OFS, 32'h08);
    wr(CTRL_OFS, 32'h18);
    wr(CTRL_OFS, 32'h00);
    rd_chk(CTRL_OFS, 32'h08);
    kickPulse <= 1'b0;
    wait_pulse(40);
    $display("Test fuse done");
  endtask : t_fuse

  // ************************************************************
  // Main sequence and watchdog
  // ************************************************************
  initial begin
    err_total = 0; comparisons = 0;
    rst = 1'b1; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'h0;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    pinReset_n = 1'b1; supplyDropReset = 1'b0; scanResetInstruction = 1'b0;
    alwaysOnFuse = 1'b0; kickPulse = 1'b0;
    hold_reset();
    t_causes();
    t_window();
    t_expiry();
    t_fuse();
    end_of_test();
  end

  // Whole run needs about 1300 clocks; cut a hang at 25000
  initial begin
    #100000;
    err_total++;
    end_of_test();
  end
endmodule : watchdog_reset_status_tb
